// ---- pkg/pla_params.svh ----
// Constants for the logic array programmer controller
// Notes on behaviour
// [RULE_01] No term satisfied: every output sits at its inactive level.
// [RULE_02] One term satisfied: outputs summing it go active, others stay inactive.
// [RULE_03] Several terms satisfied: output active if any summed term is satisfied.
// [RULE_04] Each of 48 terms ANDs chosen true or complement of 14 inputs.
// [RULE_05] Neither element programmed: input does not influence the term.
// [RULE_06] Only complement element programmed: term needs the input low.
// [RULE_07] Only true element programmed: term needs the input high.
// [RULE_08] Both elements programmed: term never satisfied.
// [RULE_09] Eight polarity elements, one per output.
// [RULE_10] Unprogrammed polarity means active low; programmed means active high.
// [RULE_11] Unprogrammed summing element isolates the term from that output.
// [RULE_12] Elements only go from unprogrammed to programmed, never back.
// [RULE_13] A term may later be added to any output sum.
// [RULE_14] Polarity changes only from active low to active high.
// [RULE_15] Two designated inputs raised to enter programming mode first.
// [RULE_16] Array select input high picks summing array, ground picks term array.
// [RULE_17] Four outputs select sector: terms 0-15, 16-31, 32-47, polarity array.
// [RULE_18] Nine inputs address one element within the sector.
// [RULE_19] After each pulse sense element; repeat pulses until it reads programmed. Code stops and sets fail once pcount_r reaches maxpulse_r.
// [RULE_20] Finally rescan all elements then apply every input combination.
// [RULE_21] Two further inputs enable pre-programming test functions.
// [RULE_22] Model arrays 48x28 AND, 48x8 OR, 8-bit polarity, zero unprogrammed.
`ifndef PLA_PARAMS_SVH
`define PLA_PARAMS_SVH
`define OFF_CTRL       12'h000
`define OFF_STATUS     12'h004
`define OFF_ADDR       12'h008
`define OFF_VECTOR     12'h00C
`define OFF_EXPECT     12'h010
`define OFF_RESULT     12'h014
`define OFF_MAXPULSE   12'h018
`define CTRL_GO_BIT    0
`define CTRL_VERIFY_BIT 1
`define CTRL_TEST_BIT  2
`define CTRL_TSEL_LSB  3
`define ADDR_ELEM_LSB  0
`define ADDR_SECT_LSB  9
`define ADDR_ARR_BIT   12
`define MAXPULSE_RST   8'h10
`define PULSE_NS       1000
`define PULSE_CYC      ((`PULSE_NS + 7) / 8)
`define NUM_TERMS      48
`define NUM_INPUTS     14
`define NUM_OUTPUTS    8
`define SECT_POL       2'h3
`endif

// ---- pkg/pla_pkg.sv ----
// Types for the logic array programmer controller
package pla_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ENTER  = 3'b001,
        ST_PULSE  = 3'b010,
        ST_SENSE  = 3'b011,
        ST_APPLY  = 3'b100,
        ST_CHECK  = 3'b101,
        ST_DONE   = 3'b110
    } state_t;
endpackage : pla_pkg

// ---- pkg/pla_mem_if.sv ----
// Record port of the sensed output memory
`timescale 1ns/1ps
interface pla_mem_if;
    logic        we;
    logic [5:0]  waddr;
    logic [7:0]  wdata;
    logic [5:0]  raddr;
    logic [7:0]  rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pla_mem_if

// ---- logic/pla_sense_mem.sv ----
// Small record of sensed outputs per verify step, registered read
`timescale 1ns/1ps
module pla_sense_mem (
    // Clock
    input wire logic pclk,
    input wire logic pclk_en,
    // Access
    pla_mem_if.mem   port
);
    logic [7:0] mem_r [0:63];
    logic [7:0] rd_r;
    always_ff @(posedge pclk) begin
        if (pclk_en && port.we) begin
            mem_r[port.waddr] <= port.wdata;
        end
    end
    always_ff @(posedge pclk) begin
        if (pclk_en) begin
            rd_r <= mem_r[port.raddr];
        end
    end
    assign port.rdata = rd_r;
endmodule : pla_sense_mem

// ---- logic/pla_programmer.sv ----
// Programmer controller driving the logic array pins, APB slave for software
`timescale 1ns/1ps
`include "pla_params.svh"
module pla_programmer (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device pins
    output logic      [13:0] dev_in,
    output logic             prog_raise,
    output logic             test_raise,
    output logic      [3:0]  sector_drive,
    output logic             pulse_en,
    input  wire logic [7:0]  dev_out,
    input  wire logic        sense_prog
);
    pla_pkg::state_t state_r;
    logic [12:0] addr_r;
    logic [13:0] vec_r;
    logic [7:0]  expect_r;
    logic [7:0]  result_r;
    logic [7:0]  maxpulse_r;
    logic [7:0]  pcount_r;
    logic [7:0]  tcount_r;
    logic        busy_r;
    logic        ok_r;
    logic        fail_r;
    logic        verify_r;
    logic        test_r;
    logic [1:0]  tsel_r;
    logic        go_pls;
    logic [13:0] pin_nxt;
    logic [3:0]  sect_nxt;
    logic        wr_acc;
    logic        rd_acc;
    pla_mem_if   mport ();

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && !penable && !pwrite;
    assign go_pls = wr_acc && (paddr == `OFF_CTRL) && pwdata[`CTRL_GO_BIT] && !busy_r;

    pla_sense_mem mem_u (
        .pclk    (pclk),
        .pclk_en (pclk_en),
        .port    (mport.mem)
    );

    // Pins used for addressing in programming mode
    always_comb begin
        pin_nxt = 14'h0000;
        pin_nxt[3] = addr_r[`ADDR_ARR_BIT];                                  // [RULE_16] [RULE_13]
        pin_nxt[8:4] = addr_r[4:0];                                          // [RULE_18]
        pin_nxt[13:10] = addr_r[8:5];                                        // [RULE_18]
        sect_nxt = 4'h0;
        sect_nxt[addr_r[10:9]] = 1'b1;                                       // [RULE_17] [RULE_14]
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r     <= 13'h0000;
            vec_r      <= 14'h0000;
            expect_r   <= 8'h00;
            maxpulse_r <= `MAXPULSE_RST;
            verify_r   <= 1'b0;
            test_r     <= 1'b0;
            tsel_r     <= 2'h0;
        end else if (pclk_en && wr_acc && !busy_r) begin
            case (paddr)
                `OFF_CTRL: begin
                    verify_r <= pwdata[`CTRL_VERIFY_BIT];
                    test_r   <= pwdata[`CTRL_TEST_BIT];
                    tsel_r   <= pwdata[`CTRL_TSEL_LSB +: 2];
                end
                `OFF_ADDR:     addr_r     <= pwdata[12:0];
                `OFF_VECTOR:   vec_r      <= pwdata[13:0];
                `OFF_EXPECT:   expect_r   <= pwdata[7:0];
                `OFF_MAXPULSE: maxpulse_r <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // APB answer: one wait-free access, read data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (pclk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `OFF_MAXPULSE);
            if (rd_acc) begin
                case (paddr)
                    `OFF_CTRL:     prdata <= {27'h0, tsel_r, test_r, verify_r, 1'b0};
                    `OFF_STATUS:   prdata <= {16'h0, pcount_r, 5'h0, fail_r, ok_r, busy_r};
                    `OFF_ADDR:     prdata <= {19'h0, addr_r};
                    `OFF_VECTOR:   prdata <= {18'h0, vec_r};
                    `OFF_EXPECT:   prdata <= {24'h0, expect_r};
                    `OFF_RESULT:   prdata <= {16'h0, mport.rdata, result_r};
                    `OFF_MAXPULSE: prdata <= {24'h0, maxpulse_r};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Sequencer: program one element or apply one verify vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= pla_pkg::ST_IDLE;
            pcount_r <= 8'h00;
            tcount_r <= 8'h00;
            busy_r   <= 1'b0;
            ok_r     <= 1'b0;
            fail_r   <= 1'b0;
            result_r <= 8'h00;
        end else if (pclk_en) begin
            case (state_r)
                pla_pkg::ST_IDLE: begin
                    if (go_pls) begin
                        busy_r   <= 1'b1;
                        ok_r     <= 1'b0;
                        fail_r   <= 1'b0;
                        pcount_r <= 8'h00;
                        tcount_r <= 8'h00;
                        // Mode bit from this same write, not the stale register
                        state_r  <= pwdata[`CTRL_VERIFY_BIT] ? pla_pkg::ST_APPLY
                                                              : pla_pkg::ST_ENTER;
                    end
                end
                pla_pkg::ST_ENTER: begin
                    state_r <= pla_pkg::ST_PULSE;                            // [RULE_15]
                end
                pla_pkg::ST_PULSE: begin
                    if (tcount_r == 8'(`PULSE_CYC - 1)) begin
                        tcount_r <= 8'h00;
                        pcount_r <= pcount_r + 8'h01;
                        state_r  <= pla_pkg::ST_SENSE;
                    end else begin
                        tcount_r <= tcount_r + 8'h01;
                    end
                end
                pla_pkg::ST_SENSE: begin
                    if (sense_prog) begin                                    // [RULE_19]
                        ok_r    <= 1'b1;
                        state_r <= pla_pkg::ST_DONE;
                    end else if (pcount_r >= maxpulse_r) begin
                        fail_r  <= 1'b1;
                        state_r <= pla_pkg::ST_DONE;
                    end else begin
                        state_r <= pla_pkg::ST_PULSE;                        // [RULE_19]
                    end
                end
                pla_pkg::ST_APPLY: begin
                    state_r <= pla_pkg::ST_CHECK;
                end
                pla_pkg::ST_CHECK: begin
                    result_r <= dev_out;                                     // [RULE_20]
                    ok_r     <= (dev_out == expect_r);
                    fail_r   <= (dev_out != expect_r);
                    state_r  <= pla_pkg::ST_DONE;
                end
                pla_pkg::ST_DONE: begin
                    busy_r  <= 1'b0;
                    state_r <= pla_pkg::ST_IDLE;
                end
                default: state_r <= pla_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_in       <= 14'h0000;
            prog_raise   <= 1'b0;
            test_raise   <= 1'b0;
            sector_drive <= 4'h0;
            pulse_en     <= 1'b0;
        end else if (pclk_en) begin
            case (state_r)
                pla_pkg::ST_ENTER, pla_pkg::ST_PULSE, pla_pkg::ST_SENSE: begin
                    prog_raise   <= 1'b1;                                    // [RULE_15]
                    dev_in       <= pin_nxt;
                    sector_drive <= sect_nxt;                                // [RULE_17]
                    pulse_en     <= (state_r == pla_pkg::ST_PULSE) &&
                                    (tcount_r != 8'(`PULSE_CYC - 1));        // [RULE_12]
                end
                default: begin
                    prog_raise   <= 1'b0;
                    pulse_en     <= 1'b0;
                    sector_drive <= 4'h0;
                    test_raise   <= test_r;                                  // [RULE_21]
                    dev_in       <= test_r ? {11'h000, tsel_r, 1'b0} : vec_r; // [RULE_20]
                end
            endcase
        end
    end

    // Sensed results kept per low vector bits for later readback
    assign mport.we    = (state_r == pla_pkg::ST_CHECK);
    assign mport.waddr = vec_r[5:0];
    assign mport.wdata = dev_out;
    assign mport.raddr = vec_r[5:0];

    property pulse_bounded;
        @(posedge pclk) disable iff (!presetn)
        $rose(pulse_en) |-> prog_raise ##0 (pulse_en && prog_raise)[*2];
    endproperty
    pulse_bounded_a: assert property (pulse_bounded)                         // [RULE_15]
        else $error("pulse without programming mode");

    sect_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)   // [RULE_17]
        pulse_en |-> $onehot(sector_drive))
        else $error("sector drive not one-hot");

    sequence sense_no;
        state_r == pla_pkg::ST_SENSE && !sense_prog && pcount_r < maxpulse_r;
    endsequence
    repeat_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE_19]
        sense_no and pclk_en |=> state_r == pla_pkg::ST_PULSE)
        else $error("no repeat pulse after failed sense");

    sequence enter_step;
        pclk_en && state_r == pla_pkg::ST_ENTER;
    endsequence
    sequence mode_raised;
        prog_raise && !pulse_en;
    endsequence
    mode_first_a: assert property (@(posedge pclk) disable iff (!presetn)    // [RULE_15]
        enter_step |=> mode_raised)
        else $error("pulse before programming mode");

    sequence test_idle;
        pclk_en && state_r == pla_pkg::ST_IDLE && test_r;
    endsequence
    test_pins_a: assert property (@(posedge pclk) disable iff (!presetn)     // [RULE_21]
        test_idle |=> test_raise && !prog_raise)
        else $error("test pins not raised while idle");

    check_result_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE_20]
        pclk_en && state_r == pla_pkg::ST_CHECK |=> result_r == $past(dev_out))
        else $error("verify result not captured");
endmodule : pla_programmer

// ---- verification/array_model.sv ----
// Behavioural model of the programmable logic array and its element arrays
`timescale 1ns/1ps
module array_model (
    // Device pins
    input  wire logic [13:0] dev_in,
    input  wire logic        prog_raise,
    input  wire logic        test_raise,
    input  wire logic [3:0]  sector_drive,
    input  wire logic        pulse_en,
    output logic      [7:0]  dev_out,
    output logic             sense_prog,
    // Pulses an element needs before it reads programmed
    input  wire logic [3:0]  pulses_needed
);
    logic [27:0] and_arr [48] = '{default: 28'h0};
    logic [7:0]  or_arr  [48] = '{default: 8'h00};
    logic [7:0]  pol          = 8'h00;
    logic [47:0] sat;
    logic [8:0]  a;
    logic [5:0]  t;
    logic [3:0]  cnt          = 4'h0;
    logic        idle_v       = 1'b0;
    logic        cur;
    assign a = {dev_in[13:10], dev_in[8:4]};
    assign t = (sector_drive[1] ? 6'h10 : sector_drive[2] ? 6'h20 : 6'h00) + {2'h0, a[3:0]};
    always_comb begin
        if (sector_drive[3]) cur = pol[a[2:0]];
        else if (dev_in[3]) cur = or_arr[t][a[6:4]];
        else cur = and_arr[t][a[8:4]];
    end
    always @(posedge prog_raise) cnt = 4'h0;
    always @(negedge pulse_en) begin
        if (prog_raise) begin
            cnt = cnt + 4'h1;
            // Elements are only ever set, never cleared
            if (cnt >= pulses_needed) begin
                if (sector_drive[3]) pol[a[2:0]] = 1'b1;
                else if (dev_in[3]) or_arr[t][a[6:4]] = 1'b1;
                else and_arr[t][a[8:4]] = 1'b1;
            end
        end
    end
    // Sense line carries no stale value outside programming mode
    always @(prog_raise) idle_v = ~idle_v;
    assign sense_prog = prog_raise ? cur : idle_v;
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            sat[i] = 1'b1;
            for (int k = 0; k < 14; k++) begin
                if ((and_arr[i][2*k] && !dev_in[k]) || (and_arr[i][2*k+1] && dev_in[k])) sat[i] = 1'b0;
            end
        end
        for (int o = 0; o < 8; o++) begin
            dev_out[o] = 1'b0;
            for (int i = 0; i < 48; i++) dev_out[o] = dev_out[o] | (sat[i] & or_arr[i][o]);
            // Outputs sit at the pull-ups while sector current is routed
            dev_out[o] = prog_raise | (dev_out[o] ~^ pol[o]);
        end
    end
endmodule : array_model

// ---- verification/tb.sv ----
// Self-checking bench for the logic array programmer controller
`timescale 1ns/1ps
`include "pla_params.svh"
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_v;
    logic        pready, pslverr, err_v, prog_raise, test_raise, pulse_en, sense_prog;
    logic [13:0] dev_in;
    logic [3:0]  sector_drive, need = 4'h1;
    logic [7:0]  dev_out;
    int          bad_count = 0, n_compared = 0;
    always #4 pclk = ~pclk;
    pla_programmer u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dev_in(dev_in), .prog_raise(prog_raise),
        .test_raise(test_raise), .sector_drive(sector_drive), .pulse_en(pulse_en),
        .dev_out(dev_out), .sense_prog(sense_prog));
    array_model u_model (.dev_in(dev_in), .prog_raise(prog_raise), .test_raise(test_raise),
        .sector_drive(sector_drive), .pulse_en(pulse_en), .dev_out(dev_out),
        .sense_prog(sense_prog), .pulses_needed(need));
    task automatic results();
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 100);
        if (pready !== 1'b1) begin
            bad_count++;
            results();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    // Polls status until the controller drops busy
    task automatic wait_idle();
        int i;
        for (i = 0; i < 400; i++) begin
            xfer(1'b0, `OFF_STATUS, 32'h0);
            if (rd_v[0] === 1'b0) break;
        end
        if (i == 400) begin
            bad_count++;
            results();
        end
    endtask : wait_idle
    task automatic prog(input logic [12:0] addr, input logic [2:0] st);
        xfer(1'b1, `OFF_ADDR, {19'h0, addr});
        xfer(1'b1, `OFF_CTRL, 32'h1);
        wait_idle();
        chk("status", {29'h0, rd_v[2:0]}, {29'h0, st});
    endtask : prog
    task automatic vfy(input logic [13:0] vec, input logic [7:0] exp);
        xfer(1'b1, `OFF_VECTOR, {18'h0, vec});
        xfer(1'b1, `OFF_EXPECT, {24'h0, exp});
        xfer(1'b1, `OFF_CTRL, 32'h3);
        wait_idle();
        chk("verify status", {29'h0, rd_v[2:0]}, 32'h2);
        xfer(1'b0, `OFF_RESULT, 32'h0);
        chk("outputs", {24'h0, rd_v[7:0]}, {24'h0, exp});
        chk("memory readback", {24'h0, rd_v[15:8]}, {24'h0, exp});
    endtask : vfy
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `OFF_MAXPULSE, 32'h0);
        chk("maxpulse", rd_v, {24'h0, `MAXPULSE_RST});
        xfer(1'b0, `OFF_STATUS, 32'h0);
        chk("status reset", rd_v, 32'h0);
        xfer(1'b0, 12'h01C, 32'h0);
        chk("slave error", {31'h0, err_v}, 32'h1);
        vfy(14'h0000, 8'hFF);
        prog(13'h0000, 3'b010);
        prog(13'h0030, 3'b010);
        prog(13'h1000, 3'b010);
        prog(13'h1020, 3'b010);
        prog(13'h0602, 3'b010);
        vfy(14'h0001, 8'hFE);
        vfy(14'h0003, 8'hFB);
        vfy(14'h0000, 8'hFB);
        vfy(14'h3FFD, 8'hFE);
        prog(13'h02A4, 3'b010);
        prog(13'h1214, 3'b010);
        prog(13'h1204, 3'b010);
        vfy(14'h0020, 8'hF8);
        vfy(14'h0021, 8'hFC);
        prog(13'h02B4, 3'b010);
        vfy(14'h0020, 8'hFB);
        need <= 4'h3;
        xfer(1'b1, `OFF_ADDR, 32'h05A8);
        xfer(1'b1, `OFF_CTRL, 32'h1);
        xfer(1'b1, `OFF_MAXPULSE, 32'h5);
        xfer(1'b0, `OFF_MAXPULSE, 32'h0);
        chk("write while busy", rd_v, 32'h10);
        wait_idle();
        chk("slow status", {29'h0, rd_v[2:0]}, 32'h2);
        chk("pulse count", {24'h0, rd_v[15:8]}, 32'h3);
        xfer(1'b1, `OFF_MAXPULSE, 32'h2);
        need <= 4'h5;
        prog(13'h0605, 3'b100);
        chk("pulse limit", {24'h0, rd_v[15:8]}, 32'h2);
        vfy(14'h0000, 8'hFB);
        xfer(1'b1, `OFF_CTRL, 32'h14);
        xfer(1'b0, `OFF_CTRL, 32'h0);
        chk("ctrl readback", rd_v, 32'h14);
        chk("test raise", {31'h0, test_raise}, 32'h1);
        chk("test select pins", {18'h0, dev_in}, 32'h4);
        xfer(1'b1, `OFF_CTRL, 32'h0);
        @(posedge pclk);
        chk("test released", {17'h0, test_raise, dev_in}, 32'h0);
        // Mid-run reset: registers return to defaults, array keeps its elements
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `OFF_MAXPULSE, 32'h0);
        chk("maxpulse after reset", rd_v, {24'h0, `MAXPULSE_RST});
        vfy(14'h0001, 8'hFE);
        results();
    end
endmodule : tb
